// ===== src/lsr_params.svh
// Purpose: Constants for the sink routing and ramp block.
// Assumes: 25 MHz mclk.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

`define LSR_ADDR_ROUTING  8'h10
`define LSR_ADDR_RAMP     8'h11
`define LSR_ADDR_RUNRAMP  8'h12
`define LSR_ADDR_ZT3      8'h7d
`define LSR_ADDR_ZT4      8'h7e

`define LSR_RST_ROUTING   6'h24
`define LSR_RST_RAMP      6'h00
`define LSR_RST_RUNRAMP   6'h00
`define LSR_RST_ZT3       8'hcc
`define LSR_RST_ZT4       8'hff

`define LSR_SINK1_LSB     0
`define LSR_SINK2_LSB     2
`define LSR_SINK3_LSB     4
`define LSR_UP_LSB        0
`define LSR_DOWN_LSB      3

`define LSR_CLK_PERIOD_NS 40
`define LSR_STEP_FAST_NS  8000
`define LSR_STEP_SLOW_NS  1024000
`define LSR_STEP_FAST_CYC ((`LSR_STEP_FAST_NS + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)
`define LSR_STEP_SLOW_CYC ((`LSR_STEP_SLOW_NS + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)

`endif

// ===== src/lsr_pkg.sv
// Purpose: Types for the sink routing and ramp block.
// Assumes: Constants come from lsr_params.svh.
// Notes:   None.
package lsr_pkg;

  typedef enum logic [1:0] {PH_OFF, PH_STARTUP, PH_RUN, PH_SHUTDOWN} lsr_phase_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } lsr_reg_req_t;

  typedef struct packed {
    lsr_phase_t phase;
    logic [7:0] level;
    logic       pwm;
  } lsr_sink_t;

  typedef struct packed {
    logic [5:0]            routing;
    logic [5:0]            ramp;
    logic [5:0]            runRamp;
    logic [7:0]            zt3;
    logic [7:0]            zt4;
    logic [7:0]            rdData;
    logic                  rdValid;
    lsr_sink_t [2:0]       sink;
  } lsr_state_t;

  typedef struct packed {
    logic [20:0] cnt;
    logic        tick;
  } lsr_tmr_state_t;

endpackage : lsr_pkg

// ===== src/lsr_step_timer.sv
// Purpose: Step interval timer for one current sink ramp.
// Assumes: Code 0 is the fast step; codes 1..7 double from the slow base.
// Notes:   Tick is a one-cycle pulse every interval while run is high.
`timescale 1ns/1ns
`default_nettype none
`include "lsr_params.svh"

module lsr_step_timer
  import lsr_pkg::*;
#(
  parameter logic [20:0] SLOW_CYC = 21'(`LSR_STEP_SLOW_CYC)
)
(
  input  wire logic       mclk,  // Clock.
  input  wire logic       rst,   // Asynchronous reset.
  input  wire logic       ce,    // Clock enable.
  input  wire logic       run,   // Count while high.
  input  wire logic [2:0] code,  // Step interval code.
  output logic            tick   // Interval elapsed pulse.
);

  localparam logic [20:0] FAST_CYC = 21'(`LSR_STEP_FAST_CYC);

  lsr_tmr_state_t state_ff;
  lsr_tmr_state_t nxt_state;
  logic [20:0]    limit;

  // Interval doubles with each code above one; code 1 is the slow base.
  assign limit = (code == 3'h0) ? FAST_CYC : 21'(SLOW_CYC << (code - 3'h1));

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (!run)
    begin
      nxt_state.cnt = 21'h0;
    end
    else if (state_ff.cnt >= limit - 21'h1)
    begin
      nxt_state.cnt  = 21'h0;
      nxt_state.tick = 1'b1;
    end
    else
    begin
      nxt_state.cnt = state_ff.cnt + 21'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= '0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;

endmodule : lsr_step_timer
`default_nettype wire

// ===== src/lsr_top.sv
// Purpose: Sink-to-group routing, ramp settings and start-up/shutdown ramping.
// Assumes: An I2C slave engine outside presents decoded register accesses.
// Notes:   Each sink owns a step timer so sinks on different groups ramp apart.
// How it works
// - Sink one group from bits 1:0.
// - Sink two group from bits 3:2.
// - Sink three group from bits 5:4.
// - Enable ramps current up at startup interval.
// - Shutdown ramps current to zero at shutdown interval.
// - Code 0 is 8 us, code 1 is 1024 us, then doubling.
// - Group C zone target three resets 0xCC.
// - Group C zone target four resets 0xFF.
// - After target reached, use run-time ramp.
`timescale 1ns/1ns
`default_nettype none
`include "lsr_params.svh"

module lsr_top
  import lsr_pkg::*;
#(
  parameter logic [20:0] SLOW_STEP_CYC = 21'(`LSR_STEP_SLOW_CYC)
)
(
  input  wire logic             mclk,         // Clock, 25 MHz.
  input  wire logic             rst,          // Asynchronous reset, active high.
  input  wire logic             ce,           // Clock enable; freezes all state when low.
  input  wire lsr_reg_req_t     regReq,       // Register access from the I2C engine.
  output logic [7:0]            regRdData,    // Read data, registered.
  output logic                  regRdValid,   // Read data valid pulse.
  input  wire logic             sinkEnable,   // Sinks switched on by the host.
  input  wire logic [2:0][7:0]  groupTarget,  // Brightness code of groups A, B, C.
  input  wire logic [2:0]       groupPwm,     // PWM level of groups A, B, C.
  output logic [2:0][1:0]       sinkGroup,    // Group index driving each sink.
  output logic [2:0][7:0]       sinkLevel,    // Ramped current code of each sink.
  output logic [2:0]            sinkPwm,      // Routed PWM of each sink.
  output logic [7:0]            zoneTarget3,  // Group C zone target three.
  output logic [7:0]            zoneTarget4   // Group C zone target four.
);

  lsr_state_t       state_ff;
  lsr_state_t       nxt_state;
  logic [2:0]       tmrRun;
  logic [2:0][2:0]  tmrCode;
  logic [2:0]       tmrTick;
  logic [2:0][7:0]  sinkGoal;

  // Two-bit routing field to group index; 1x is group C.
  function automatic logic [1:0] grpIdx(input logic [1:0] field);
    grpIdx = field[1] ? 2'h2 : {1'b0, field[0]};
  endfunction : grpIdx

  function automatic logic [1:0] sinkField(input logic [5:0] routing, input int idx);
    sinkField = routing[2*idx +: 2];
  endfunction : sinkField

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_sink
      logic [1:0] grp;
      lsr_sink_t  s;

      assign s   = state_ff.sink[i];
      assign grp = grpIdx(sinkField(state_ff.routing, i));

      // Shutdown always heads for zero, whatever the group target is.
      assign sinkGoal[i] = (s.phase == PH_SHUTDOWN || s.phase == PH_OFF) ? 8'h0 : groupTarget[grp];

      assign tmrRun[i] = (s.phase != PH_OFF) && (s.level != sinkGoal[i]);

      always_comb
      begin
        case (s.phase)
          PH_STARTUP:  tmrCode[i] = state_ff.ramp[`LSR_UP_LSB +: 3];
          PH_SHUTDOWN: tmrCode[i] = state_ff.ramp[`LSR_DOWN_LSB +: 3];
          PH_RUN:      tmrCode[i] = (s.level < sinkGoal[i]) ?
                                    state_ff.runRamp[`LSR_UP_LSB +: 3] :
                                    state_ff.runRamp[`LSR_DOWN_LSB +: 3];
          default:     tmrCode[i] = 3'h0;
        endcase
      end

      lsr_step_timer #(
        .SLOW_CYC (SLOW_STEP_CYC)
      ) u_timer (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .run  (tmrRun[i]),
        .code (tmrCode[i]),
        .tick (tmrTick[i])
      );

      assign sinkGroup[i] = grp;
      assign sinkLevel[i] = s.level;
      assign sinkPwm[i]   = s.pwm;
    end
  endgenerate

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rdValid = 1'b0;

    // Register writes; bits 7:6 of the configuration bytes are not stored.
    if (regReq.wrEn)
    begin
      case (regReq.addr)
        `LSR_ADDR_ROUTING: nxt_state.routing = regReq.wrData[5:0];
        `LSR_ADDR_RAMP:    nxt_state.ramp    = regReq.wrData[5:0];
        `LSR_ADDR_RUNRAMP: nxt_state.runRamp = regReq.wrData[5:0];
        `LSR_ADDR_ZT3:     nxt_state.zt3     = regReq.wrData;
        `LSR_ADDR_ZT4:     nxt_state.zt4     = regReq.wrData;
        default:           nxt_state.routing = state_ff.routing;
      endcase
    end

    // Reads of unmapped addresses return zero.
    if (regReq.rdEn)
    begin
      nxt_state.rdValid = 1'b1;
      case (regReq.addr)
        `LSR_ADDR_ROUTING: nxt_state.rdData = {2'b00, state_ff.routing};
        `LSR_ADDR_RAMP:    nxt_state.rdData = {2'b00, state_ff.ramp};
        `LSR_ADDR_RUNRAMP: nxt_state.rdData = {2'b00, state_ff.runRamp};
        `LSR_ADDR_ZT3:     nxt_state.rdData = state_ff.zt3;
        `LSR_ADDR_ZT4:     nxt_state.rdData = state_ff.zt4;
        default:           nxt_state.rdData = 8'h00;
      endcase
    end

    for (int i = 0; i < 3; i++)
    begin
      nxt_state.sink[i].pwm = groupPwm[grpIdx(sinkField(state_ff.routing, i))];

      // One code per elapsed interval, toward the current goal.
      if (tmrTick[i] && state_ff.sink[i].level < sinkGoal[i])
      begin
        nxt_state.sink[i].level = state_ff.sink[i].level + 8'h01;
      end
      else if (tmrTick[i] && state_ff.sink[i].level > sinkGoal[i])
      begin
        nxt_state.sink[i].level = state_ff.sink[i].level - 8'h01;
      end

      case (state_ff.sink[i].phase)
        PH_OFF:
        begin
          nxt_state.sink[i].level = 8'h00;
          if (sinkEnable)
          begin
            nxt_state.sink[i].phase = PH_STARTUP;
          end
        end
        PH_STARTUP:
        begin
          if (!sinkEnable)
          begin
            nxt_state.sink[i].phase = PH_SHUTDOWN;
          end
          else if (state_ff.sink[i].level == sinkGoal[i])
          begin
            nxt_state.sink[i].phase = PH_RUN;
          end
        end
        PH_RUN:
        begin
          if (!sinkEnable)
          begin
            nxt_state.sink[i].phase = PH_SHUTDOWN;
          end
        end
        PH_SHUTDOWN:
        begin
          if (sinkEnable)
          begin
            nxt_state.sink[i].phase = PH_STARTUP;
          end
          else if (state_ff.sink[i].level == 8'h00)
          begin
            nxt_state.sink[i].phase = PH_OFF;
          end
        end
        default:
        begin
          nxt_state.sink[i].phase = PH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_ff         <= '0;
      state_ff.routing <= `LSR_RST_ROUTING;
      state_ff.ramp    <= `LSR_RST_RAMP;
      state_ff.runRamp <= `LSR_RST_RUNRAMP;
      state_ff.zt3     <= `LSR_RST_ZT3;
      state_ff.zt4     <= `LSR_RST_ZT4;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
    end
  end

  assign regRdData   = state_ff.rdData;
  assign regRdValid  = state_ff.rdValid;
  assign zoneTarget3 = state_ff.zt3;
  assign zoneTarget4 = state_ff.zt4;

endmodule : lsr_top
`default_nettype wire

// ===== tb/lsr_props.sv
// Purpose: Port-level checks on lsr_top.
// Assumes: One clock domain, reset active high.
// Notes:   Step, hold and shutdown checks watch sink one; the other sinks share its logic.
`timescale 1ns/1ns
`default_nettype none
module lsr_props
  import lsr_pkg::*;
#(
  parameter logic [20:0] SLOW_STEP_CYC = 21'd8
)
(
  input wire logic            mclk,        // Clock.
  input wire logic            rst,         // Reset.
  input wire logic            ce,          // Clock enable.
  input wire lsr_reg_req_t    regReq,      // Register access.
  input wire logic [7:0]      regRdData,   // Read data.
  input wire logic            regRdValid,  // Read valid.
  input wire logic            sinkEnable,  // Sinks on.
  input wire logic [2:0][1:0] sinkGroup,   // Group per sink.
  input wire logic [2:0][7:0] sinkLevel,   // Level per sink.
  input wire logic [7:0]      zoneTarget3, // Zone target three.
  input wire logic [7:0]      zoneTarget4  // Zone target four.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_route1;
    ce && regReq.wrEn && regReq.addr == 8'h10 |=>
      sinkGroup[0] == ($past(regReq.wrData[1]) ? 2'h2 : {1'b0, $past(regReq.wrData[0])});
  endproperty
  a_route1: assert property (p_route1) else $error("sink one group wrong");
  property p_route2;
    ce && regReq.wrEn && regReq.addr == 8'h10 |=>
      sinkGroup[1] == ($past(regReq.wrData[3]) ? 2'h2 : {1'b0, $past(regReq.wrData[2])});
  endproperty
  a_route2: assert property (p_route2) else $error("sink two group wrong");
  property p_route3;
    ce && regReq.wrEn && regReq.addr == 8'h10 |=>
      sinkGroup[2] == ($past(regReq.wrData[5]) ? 2'h2 : {1'b0, $past(regReq.wrData[4])});
  endproperty
  a_route3: assert property (p_route3) else $error("sink three group wrong");
  // A change of at most one code wraps the difference plus one into 0..2.
  property p_step;
    8'(sinkLevel[0] - $past(sinkLevel[0]) + 8'h01) <= 8'h02;
  endproperty
  a_step: assert property (p_step) else $error("level moved more than one code");
  property p_hold;
    $changed(sinkLevel[0]) |=> $stable(sinkLevel[0]) [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("level stepped too soon");
  property p_down;
    !sinkEnable && !$past(sinkEnable) |=> sinkLevel[0] <= $past(sinkLevel[0]);
  endproperty
  a_down: assert property (p_down) else $error("level rose while shut down");
  property p_rst;
    $fell(rst) |-> zoneTarget3 == 8'hcc && zoneTarget4 == 8'hff;
  endproperty
  a_rst: assert property (p_rst) else $error("zone target reset value wrong");
  property p_hi;
    ce && regReq.rdEn && regReq.addr inside {8'h10, 8'h11} |=> regRdValid && regRdData[7:6] == 2'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("unused bits read nonzero");
  // With the clock enable low no stored value may move, ramp or register.
  property p_freeze;
    !ce |=> $stable(sinkLevel) && $stable(sinkGroup) && $stable(zoneTarget3) && $stable(zoneTarget4);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : lsr_props
bind lsr_top lsr_props #(.SLOW_STEP_CYC(SLOW_STEP_CYC)) i_lsr_props (.mclk, .rst, .ce, .regReq, .regRdData,
  .regRdValid, .sinkEnable, .sinkGroup, .sinkLevel, .zoneTarget3, .zoneTarget4);
`default_nettype wire

// ===== tb/lsr_host.sv
// Purpose: Host model issuing decoded register accesses.
// Assumes: Requests launch at the falling edge, one-cycle strobes.
// Notes:   Idle address and data invert so stale values never look valid.
`timescale 1ns/1ns
`default_nettype none
module lsr_host
  import lsr_pkg::*;
(
  input  wire logic       mclk,              // Clock.
  input  wire logic [7:0] rdData,            // Read data.
  output var lsr_reg_req_t req               // Access request.
);
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    req <= '{wrEn: w, rdEn: !w, addr: a, wrData: d};
    @(negedge mclk);
    q = rdData;
    req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : acc
endmodule : lsr_host
`default_nettype wire

// ===== tb/led_sink_routing_and_ramp_tb.sv
// Purpose: Self-checking bench for lsr_top.
// Assumes: Slow step shortened to 8 cycles.
// Notes:   Register model is an associative array.
`timescale 1ns/1ns
`default_nettype none
`define CHK(NM, EX, GT) begin check_count++; if ((GT) !== (EX)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", NM, EX, GT); end end
module led_sink_routing_and_ramp_tb
  import lsr_pkg::*;
;
  logic            mclk, rst, ce, sinkEnable, regRdValid;
  logic [2:0]      groupPwm, sinkPwm;
  logic [2:0][7:0] groupTarget, sinkLevel;
  logic [2:0][7:0] frozenLevel;
  logic [2:0][1:0] sinkGroup;
  logic [7:0]      regRdData, zoneTarget3, zoneTarget4, q, a;
  lsr_reg_req_t    regReq;
  int              fail_count, check_count, g;
  logic [31:0]     seed = 32'hfd8e9818;
  logic [7:0]      regs [logic [7:0]];
  logic [7:0]      adr [6] = '{8'h10, 8'h11, 8'h12, 8'h7d, 8'h7e, 8'h20};
  lsr_top #(.SLOW_STEP_CYC(21'd8)) i_lsr_top (.mclk, .rst, .ce, .regReq, .regRdData, .regRdValid,
    .sinkEnable, .groupTarget, .groupPwm, .sinkGroup, .sinkLevel, .sinkPwm, .zoneTarget3, .zoneTarget4);
  lsr_host i_lsr_host (.mclk, .rdData(regRdData), .req(regReq));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic model_reset();
    regs[8'h10] = 8'h24;
    regs[8'h11] = 8'h00;
    regs[8'h12] = 8'h00;
    regs[8'h7d] = 8'hcc;
    regs[8'h7e] = 8'hff;
  endtask : model_reset
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    i_lsr_host.acc(1'b1, ad, d, q);
    if (ad inside {8'h10, 8'h11, 8'h12})
      regs[ad] = d & 8'h3f;
    else if (ad inside {8'h7d, 8'h7e})
      regs[ad] = d;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    i_lsr_host.acc(1'b0, ad, 8'h00, q);
    `CHK("valid", 1'b1, regRdValid)
    `CHK("rdata", (regs.exists(ad) ? regs[ad] : 8'h00), q)
  endtask : rd
  // Times two consecutive steps of sink one; the second is a whole interval.
  task automatic gap(input int n);
    int c;
    logic [7:0] l;
    for (int k = 0; k < 2; k++)
    begin
      l = sinkLevel[0];
      c = 0;
      while (sinkLevel[0] === l && c < 5000)
      begin
        @(negedge mclk);
        c++;
      end
    end
    `CHK("step gap", 1'b1, c >= n && c <= n + 1)
    if (c >= 5000) end_of_test();
  endtask : gap
  task automatic wait_lvl(input logic [7:0] v);
    int c = 0;
    while (sinkLevel[0] !== v && c < 20000)
    begin
      @(negedge mclk);
      c++;
    end
    `CHK("level", {3{v}}, sinkLevel)
    if (c >= 20000) end_of_test();
  endtask : wait_lvl
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    sinkEnable = 1'b0;
    groupTarget = '0;
    groupPwm = '0;
    model_reset();
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    foreach (adr[i]) rd(adr[i]);
    for (int i = 0; i < 30; i++)
    begin
      a = adr[rnd() % 6];
      wr(a, 8'(rnd()));
      groupPwm = 3'(rnd());
      rd(a);
      @(negedge mclk);
      `CHK("zone", regs[8'h7d], zoneTarget3)
      `CHK("zone4", regs[8'h7e], zoneTarget4)
      for (int s = 0; s < 3; s++)
      begin
        g = regs[8'h10][2*s+1] ? 2 : int'(regs[8'h10][2*s]);
        `CHK("group", 2'(g), sinkGroup[s])
        `CHK("pwm", groupPwm[g], sinkPwm[s])
      end
    end
    wr(8'h10, 8'h24);
    wr(8'h11, 8'h38);
    wr(8'h12, 8'h02);
    groupTarget = {3{8'h03}};
    sinkEnable = 1'b1;
    gap(200);
    wait_lvl(8'h03);
    // Let the phase settle into run before retargeting.
    repeat (2) @(negedge mclk);
    groupTarget = {3{8'h05}};
    gap(16);
    wait_lvl(8'h05);
    sinkEnable = 1'b0;
    gap(512);
    // Clock enable low must freeze the ramp and drop a register write.
    ce = 1'b0;
    frozenLevel = sinkLevel;
    i_lsr_host.acc(1'b1, 8'h7e, 8'h5a, q);
    repeat (600) @(negedge mclk);
    `CHK("frozen level", frozenLevel, sinkLevel)
    `CHK("frozen write", regs[8'h7e], zoneTarget4)
    ce = 1'b1;
    wait_lvl(8'h00);
    // A reset after the shutdown ramp has reached zero must bring back the default routing and zone targets.
    wr(8'h10, 8'h3f);
    wr(8'h7d, 8'h11);
    wr(8'h7e, 8'h22);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    model_reset();
    `CHK("group reset", 6'h24, sinkGroup)
    foreach (adr[i]) rd(adr[i]);
    `CHK("zone3 reset", 8'hcc, zoneTarget3)
    `CHK("zone4 reset", 8'hff, zoneTarget4)
    end_of_test();
  end
endmodule : led_sink_routing_and_ramp_tb
`default_nettype wire
